// [design/dpc_pkg.sv]
// Package: register map, field positions and reset values of the datapath configuration block.
package dpc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    // Printed offsets 0x22 and 0x23 are not multiples of four, so they are indices.
    localparam logic [7:0]  DPC_IDX_DATAPATH   = 8'h22;
    localparam logic [7:0]  DPC_IDX_RX_MODE    = 8'h23;
    localparam logic [7:0]  DPC_IDX_FC_CONTROL = 8'h30;
    localparam logic [31:0] DPC_ADDR_DATAPATH   = {22'h000000, DPC_IDX_DATAPATH, 2'h0};
    localparam logic [31:0] DPC_ADDR_RX_MODE    = {22'h000000, DPC_IDX_RX_MODE, 2'h0};
    localparam logic [31:0] DPC_ADDR_FC_CONTROL = {22'h000000, DPC_IDX_FC_CONTROL, 2'h0};

    // ****************************************
    // Field positions
    // ****************************************
    localparam int DPC_BIT_LOCK      = 7;
    localparam int DPC_BIT_UNFRAMED  = 6;
    localparam int DPC_BIT_POLARITY  = 5;
    localparam int DPC_BIT_AUD_SUPP  = 4;
    localparam int DPC_BIT_FOUR_OVR  = 3;
    localparam int DPC_BIT_VID18     = 2;
    localparam int DPC_BIT_INBAND    = 1;
    localparam int DPC_BIT_FOUR_EN   = 0;
    localparam int DPC_BIT_REPEATER  = 2;
    localparam int DPC_BIT_SURR_OK   = 0;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [7:0] DPC_RESET_DATAPATH = 8'h00;
    localparam logic [6:0] DPC_FC_MASK        = 7'h7F;
endpackage

// [design/dpc_datapath_config.sv]
// Datapath configuration register with forward-channel loading and APB access.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module dpc_datapath_config (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Forward channel from the remote serializer
    input  wire logic        fc_load,
    input  wire logic [6:0]  fc_config,
    // Strapped repeater mode level
    input  wire logic        repeater_strap,
    // Datapath controls
    output logic             unframed_rgb,
    output logic             data_enable_polarity,
    output logic             content_protect_enable,
    output logic             packet_audio_on_rgb,
    output logic             video_18bit,
    output logic             audio_inband,
    output logic             four_channel_audio,
    output logic             surround_unsupported
);
    import dpc_pkg::*;

    // ****************************************
    // Decode functions
    // ****************************************
    // Each control is decoded by one function, so the reset level of an output is the
    // decode of the register's reset value and can never drift away from it.
    function automatic logic dec_unframed(input logic [7:0] cfg);
        return cfg[DPC_BIT_UNFRAMED];
    endfunction

    function automatic logic dec_polarity(input logic [7:0] cfg);
        return cfg[DPC_BIT_POLARITY];
    endfunction

    // Unframed video gives the cipher no framing, so content protection is switched off.
    function automatic logic dec_content_protect(input logic [7:0] cfg);
        return ~cfg[DPC_BIT_UNFRAMED];
    endfunction

    // Packetized audio needs framed video and must not be suppressed.
    function automatic logic dec_packet_audio(input logic [7:0] cfg);
        return ~cfg[DPC_BIT_UNFRAMED] & ~cfg[DPC_BIT_AUD_SUPP];
    endfunction

    function automatic logic dec_video_18bit(input logic [7:0] cfg);
        return cfg[DPC_BIT_VID18];
    endfunction

    function automatic logic dec_inband(input logic [7:0] cfg);
        return cfg[DPC_BIT_INBAND];
    endfunction

    // Without the override the enable bit has no effect and four channels stay off.
    function automatic logic dec_four_channel(input logic [7:0] cfg);
        return cfg[DPC_BIT_FOUR_OVR] & cfg[DPC_BIT_FOUR_EN];
    endfunction

    // Only the repeater case with 18-bit video loses surround audio.
    function automatic logic dec_surround_unsupported(input logic [7:0] cfg, input logic rep);
        return rep & cfg[DPC_BIT_VID18];
    endfunction

    // Full-word compare: an alias in the upper address bits would hide a software bug.
    function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
        return addr == reg_addr;
    endfunction

    // Status word of the read-only receiver mode register; unlisted bits read as zero.
    function automatic logic [7:0] dec_rx_status(input logic rep, input logic surround_ok);
        logic [7:0] status;
        status                   = 8'h00;
        status[DPC_BIT_REPEATER] = rep;
        status[DPC_BIT_SURR_OK]  = surround_ok;
        return status;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] datapath_configuration;
    logic [2:0] rep_sync;
    logic       repeater_mode;
    logic [7:0] fc_update_count;

    // ****************************************
    // APB decode
    // ****************************************
    wire        apb_access   = psel & penable;
    wire        apb_write    = apb_access & pwrite;
    wire        access_first = apb_access & ~pready;
    wire        hit_dp       = addr_hit(paddr, DPC_ADDR_DATAPATH);
    wire        hit_rx       = addr_hit(paddr, DPC_ADDR_RX_MODE);
    wire        hit_fc       = addr_hit(paddr, DPC_ADDR_FC_CONTROL);
    wire        hit_any      = hit_dp | hit_rx | hit_fc;
    wire        wr_dp        = apb_write & hit_dp;
    wire        wr_fc        = apb_write & hit_fc;
    wire        locked       = datapath_configuration[DPC_BIT_LOCK];
    wire        fc_accept    = fc_load & ~locked;
    wire [7:0]  rx_status    = dec_rx_status(repeater_mode, ~surround_unsupported);
    wire [31:0] rd_mux       = hit_dp ? {24'h000000, datapath_configuration} :
                               hit_rx ? {24'h000000, rx_status} :
                               hit_fc ? {24'h000000, fc_update_count} : 32'h00000000;

    // ****************************************
    // Configuration register
    // ****************************************
    // A forward-channel load in the same cycle as a local write wins on bits 6 to 0,
    // since the serializer is the master copy until software sets the lock.
    // The forward channel carries bits 6 to 0 only; the lock bit belongs to software.
    wire [6:0] fc_low_bits   = fc_config & DPC_FC_MASK;
    wire       next_lock_bit = wr_dp ? pwdata[DPC_BIT_LOCK] : locked;
    wire [7:0] local_value   = wr_dp ? pwdata[7:0] : datapath_configuration;
    wire [7:0] next_datapath_configuration =
        fc_accept ? {next_lock_bit, fc_low_bits} : local_value;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            datapath_configuration <= DPC_RESET_DATAPATH;
        end else begin
            datapath_configuration <= next_datapath_configuration;
        end
    end

    // ****************************************
    // Repeater strap synchroniser
    // ****************************************
    // Strap passes three flops; repeater mode follows once the last two agree, so a
    // slow or bouncing strap edge cannot toggle the mode on a single sample.
    wire next_repeater_mode = (rep_sync[2] == rep_sync[1]) ? rep_sync[2] : repeater_mode;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rep_sync <= 3'h0;
        end else begin
            rep_sync <= {rep_sync[1:0], repeater_strap};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            repeater_mode <= 1'b0;
        end else begin
            repeater_mode <= next_repeater_mode;
        end
    end

    // ****************************************
    // Forward-channel update counter
    // ****************************************
    // Counts accepted loads only, so software can tell a refused update from a lost one.
    // It wraps; a write of any value clears it, and an accepted load in the same cycle wins.
    wire [7:0] next_fc_update_count = fc_accept ? 8'(fc_update_count + 8'h01) :
                                      wr_fc     ? 8'h00 : fc_update_count;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fc_update_count <= 8'h00;
        end else begin
            fc_update_count <= next_fc_update_count;
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    // One wait state: pready rises the cycle after the access phase starts. Registering
    // the answer costs a cycle per access but keeps the decode off the bus return path.
    wire        next_pready  = access_first;
    wire [31:0] next_prdata  = (access_first & ~pwrite) ? rd_mux : 32'h00000000;
    wire        next_pslverr = access_first & ~hit_any;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
        end else begin
            pready <= next_pready;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= next_pslverr;
        end
    end

    // ****************************************
    // Datapath controls
    // ****************************************
    // Every control is a registered decode, one cycle behind the register, so the
    // outputs never glitch while a forward-channel load and a write meet.
    wire next_unframed_rgb           = dec_unframed(datapath_configuration);
    wire next_data_enable_polarity   = dec_polarity(datapath_configuration);
    wire next_content_protect_enable = dec_content_protect(datapath_configuration);
    wire next_packet_audio_on_rgb    = dec_packet_audio(datapath_configuration);
    wire next_video_18bit            = dec_video_18bit(datapath_configuration);
    wire next_audio_inband           = dec_inband(datapath_configuration);
    wire next_four_channel_audio     = dec_four_channel(datapath_configuration);
    wire next_surround_unsupported   =
        dec_surround_unsupported(datapath_configuration, repeater_mode);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            unframed_rgb <= dec_unframed(DPC_RESET_DATAPATH);
        end else begin
            unframed_rgb <= next_unframed_rgb;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            data_enable_polarity <= dec_polarity(DPC_RESET_DATAPATH);
        end else begin
            data_enable_polarity <= next_data_enable_polarity;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            content_protect_enable <= dec_content_protect(DPC_RESET_DATAPATH);
        end else begin
            content_protect_enable <= next_content_protect_enable;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            packet_audio_on_rgb <= dec_packet_audio(DPC_RESET_DATAPATH);
        end else begin
            packet_audio_on_rgb <= next_packet_audio_on_rgb;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            video_18bit <= dec_video_18bit(DPC_RESET_DATAPATH);
        end else begin
            video_18bit <= next_video_18bit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            audio_inband <= dec_inband(DPC_RESET_DATAPATH);
        end else begin
            audio_inband <= next_audio_inband;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            four_channel_audio <= dec_four_channel(DPC_RESET_DATAPATH);
        end else begin
            four_channel_audio <= next_four_channel_audio;
        end
    end

    // Repeater mode reads as clear during reset, so the flag starts clear as well.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            surround_unsupported <= dec_surround_unsupported(DPC_RESET_DATAPATH, 1'b0);
        end else begin
            surround_unsupported <= next_surround_unsupported;
        end
    end
endmodule

`default_nettype wire

// [bench/dpc_fc_model.sv]
// Remote serializer model that loads settings over the forward channel.
`timescale 1ns/100ps
`default_nettype none
module dpc_fc_model (
    input  wire logic       sys_clk,
    output logic            fc_load   = 1'b0,
    output logic [6:0]      fc_config = 7'h00
);
    // One-cycle update; afterwards the lines show the inverse so stale data never looks valid.
    task automatic send(input logic [6:0] v);
        @(posedge sys_clk);
        fc_load   <= 1'b1;
        fc_config <= v;
        @(posedge sys_clk);
        fc_load   <= 1'b0;
        fc_config <= ~v;
    endtask
endmodule
`default_nettype wire

// [bench/dpc_datapath_config_assertions.sv]
// Port checker for the datapath configuration block.
`timescale 1ns/100ps
`default_nettype none
module dpc_datapath_config_assertions import dpc_pkg::*; (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    // Datapath controls
    input wire logic        unframed_rgb,
    input wire logic        data_enable_polarity,
    input wire logic        content_protect_enable,
    input wire logic        packet_audio_on_rgb,
    input wire logic        video_18bit,
    input wire logic        audio_inband,
    input wire logic        four_channel_audio,
    input wire logic        surround_unsupported
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire logic rd_dp = pready && !pwrite && paddr == DPC_ADDR_DATAPATH;
    cp_tracks_a: assert property (content_protect_enable == !unframed_rgb)
        else $error("content protect does not follow unframed mode");
    audio_block_a: assert property (unframed_rgb |-> !packet_audio_on_rgb)
        else $error("packet audio not blocked");
    rd_fields_a: assert property (rd_dp |-> {prdata[6], prdata[5], prdata[2], prdata[1]}
        == {unframed_rgb, data_enable_polarity, video_18bit, audio_inband})
        else $error("field outputs differ from register");
    rd_audio_a: assert property (rd_dp |-> packet_audio_on_rgb == !(prdata[6] | prdata[4])
        && four_channel_audio == (prdata[3] & prdata[0])) else $error("audio outputs wrong");
    pready_once_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    pready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    slverr_ack_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    rd_upper_a: assert property (prdata[31:8] == 24'h000000) else $error("upper read bits set");
    surround_mode_a: assert property (surround_unsupported |-> video_18bit)
        else $error("surround flag without 18-bit video");
    cover property (rd_dp && prdata[7]);
    cover property (pslverr);
    cover property (surround_unsupported);
endmodule
bind dpc_datapath_config dpc_datapath_config_assertions chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
    .unframed_rgb(unframed_rgb), .data_enable_polarity(data_enable_polarity),
    .content_protect_enable(content_protect_enable), .packet_audio_on_rgb(packet_audio_on_rgb),
    .video_18bit(video_18bit), .audio_inband(audio_inband),
    .four_channel_audio(four_channel_audio), .surround_unsupported(surround_unsupported));
`default_nettype wire

// [bench/dpc_datapath_config_tb.sv]
// Self-checking bench for the datapath configuration block.
`timescale 1ns/100ps
`default_nettype none
module dpc_datapath_config_tb;
    import dpc_pkg::*;
    logic        sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, rep = 1;
    logic [31:0] paddr = 0, pwdata = 0;
    logic [32:0] rd;
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, fc_load;
    wire logic [6:0] fc_config;
    wire logic [7:0] o;
    int          error_cnt = 0, n_tests = 0;
    logic [7:0]  vals[9] = '{8'h81, 8'h82, 8'h84, 8'h88, 8'h89, 8'h90, 8'hA0, 8'hC0, 8'hD5};
    always #50 sys_clk = ~sys_clk;
    dpc_fc_model fc (.sys_clk(sys_clk), .fc_load(fc_load), .fc_config(fc_config));
    dpc_datapath_config dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .fc_load(fc_load), .fc_config(fc_config), .repeater_strap(rep),
        .unframed_rgb(o[7]), .data_enable_polarity(o[6]), .content_protect_enable(o[5]),
        .packet_audio_on_rgb(o[4]), .video_18bit(o[3]), .audio_inband(o[2]),
        .four_channel_audio(o[1]), .surround_unsupported(o[0]));
    task automatic chk(input logic [32:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic [7:0] expo(input logic [7:0] r);
        return {r[6], r[5], ~r[6], ~(r[6] | r[4]), r[2], r[1], r[3] & r[0], r[2]};
    endfunction
    task automatic t_reset;
        apb(0, DPC_ADDR_DATAPATH, 0);
        chk(rd, 0);
        chk(o, 8'h30);
        apb(0, DPC_ADDR_RX_MODE, 0);
        chk(rd, 33'h5);
    endtask
    task automatic t_fields;
        foreach (vals[i]) begin
            apb(1, DPC_ADDR_DATAPATH, {24'h0, vals[i]});
            apb(0, DPC_ADDR_DATAPATH, 0);
            chk(rd, vals[i]);
            chk(o, expo(vals[i]));
        end
    endtask
    task automatic t_fc;
        apb(1, DPC_ADDR_DATAPATH, 0);
        fc.send(7'h55);
        apb(0, DPC_ADDR_DATAPATH, 0);
        chk(rd, 33'h55);
        apb(1, DPC_ADDR_DATAPATH, 32'h0A);
        fc.send(7'h3F);
        apb(0, DPC_ADDR_DATAPATH, 0);
        chk(rd, 33'h3F);
        apb(1, DPC_ADDR_DATAPATH, 32'h92);
        fc.send(7'h6D);
        apb(0, DPC_ADDR_DATAPATH, 0);
        chk(rd, 33'h92);
        apb(0, 32'h04, 0);
        chk(rd, 33'h100000000);
    endtask
    // Two loads were accepted above and the locked one refused; a write clears the count.
    task automatic t_count;
        apb(0, DPC_ADDR_FC_CONTROL, 0);
        chk(rd, 33'h2);
        apb(1, DPC_ADDR_FC_CONTROL, 32'h5A);
        apb(0, DPC_ADDR_FC_CONTROL, 0);
        chk(rd, 33'h0);
    endtask
    // Reset in mid-run returns a locked, non-zero register to zero.
    task automatic t_rerun;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(o, 8'h30);
        reset_n <= 1'b1;
        apb(0, DPC_ADDR_DATAPATH, 0);
        chk(rd, 0);
        apb(1, DPC_ADDR_RX_MODE, 32'hFF);
        apb(0, DPC_ADDR_RX_MODE, 0);
        chk(rd, 33'h5);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog sized well above the roughly 160 cycles that the tests need.
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset;
        t_fields;
        t_fc;
        t_count;
        t_rerun;
        tally_and_finish;
    end
endmodule
`default_nettype wire
